// >>> zac_aux_line.sv
`timescale 1ns/1ps
`default_nettype none

module zac_aux_line
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    input  wire logic inv_i,
    input  wire logic drive_i,
    input  wire logic occ_i,
    output logic      act_o,
    output logic      pin_o,
    output logic      pin_oe_o
);

    logic sync1_ff;
    logic sync2_ff;

    // ------------------------------------------------------------------
    // Pin capture and drive
    // ------------------------------------------------------------------
    // Two stages bring the pin into the clock domain; the pin outputs are registered.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end
        else
        begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            pin_o    <= occ_i ^ inv_i;
            pin_oe_o <= drive_i;
        end
    end

    // With inversion the function is active while the pin is off.
    assign act_o = sync2_ff ^ inv_i;

endmodule : zac_aux_line

`default_nettype wire

// >>> zac_feeder_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Feeding equipment in front of the head zone
// ------------------------------------------------------------
module zac_feeder_model
(
    input  wire logic       clk_i,
    input  wire logic       feed_i,
    input  wire logic       take_i,
    input  wire logic       busy_i,
    output logic            item_o,
    output logic      [7:0] fed_o
);
    // Starts with an empty head sensor and nothing delivered.
    initial
    begin
        item_o = 1'b0;
        fed_o  = 8'h00;
    end

    // Puts one item down only while the occupancy line shows the zone empty.
    always @(posedge clk_i)
    begin
        if (take_i)
            item_o <= 1'b0;
        else if (feed_i && !busy_i && !item_o)
        begin
            item_o <= 1'b1;
            fed_o  <= fed_o + 8'h01;
        end
    end
endmodule : zac_feeder_model

`default_nettype wire

// >>> zac_lane_qual.sv
`timescale 1ns/1ps
`default_nettype none

module zac_lane_qual
#(
    parameter int W = 16
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic         level_i,
    input  wire logic [W-1:0] block_ms_i,
    input  wire logic [W-1:0] clear_ms_i,
    output logic              full_o
);

    zac_pkg::zac_qual_e state_ff;
    zac_pkg::zac_qual_e nxt_state;
    logic [W-1:0]       cnt_ff;
    logic [W-1:0]       nxt_cnt;

    // ------------------------------------------------------------------
    // Block and clear qualification
    // ------------------------------------------------------------------
    // A level change in mid-count abandons the count and returns to the settled state it left.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            zac_pkg::Q_CLEAR:
            begin
                nxt_cnt = '0;
                if (level_i)
                    nxt_state = zac_pkg::Q_BLOCKING;
            end
            zac_pkg::Q_BLOCKING:
            begin
                if (!level_i)
                begin
                    nxt_state = zac_pkg::Q_CLEAR;
                    nxt_cnt   = '0;
                end
                else if (cnt_ff >= block_ms_i)
                begin
                    nxt_state = zac_pkg::Q_BLOCKED;
                    nxt_cnt   = '0;
                end
                else if (tick_i)
                    nxt_cnt = cnt_ff + W'(1);
            end
            zac_pkg::Q_BLOCKED:
            begin
                nxt_cnt = '0;
                if (!level_i)
                    nxt_state = zac_pkg::Q_CLEARING;
            end
            zac_pkg::Q_CLEARING:
            begin
                if (level_i)
                begin
                    nxt_state = zac_pkg::Q_BLOCKED;
                    nxt_cnt   = '0;
                end
                else if (cnt_ff >= clear_ms_i)
                begin
                    nxt_state = zac_pkg::Q_CLEAR;
                    nxt_cnt   = '0;
                end
                else if (tick_i)
                    nxt_cnt = cnt_ff + W'(1);
            end
            default:
            begin
                nxt_state = zac_pkg::Q_CLEAR;
                nxt_cnt   = '0;
            end
        endcase
    end

    // State and count registers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= zac_pkg::Q_CLEAR;
            cnt_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Accumulate holds in the blocked and clearing states.
    assign full_o = state_ff[1];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    block_wait_a: assert property ($rose(full_o) |-> $past(level_i, 2) && $past(level_i))
        else $error("Lane full asserted without a held input.");
    clear_wait_a: assert property ($fell(full_o) |-> !$past(level_i, 2) && !$past(level_i))
        else $error("Lane full released without a held clear.");
    cancel_a: assert property ((state_ff == zac_pkg::Q_BLOCKING && !level_i) |=> !full_o)
        else $error("Aborted block count still set lane full.");

endmodule : zac_lane_qual

`default_nettype wire

// >>> zac_pkg.sv
package zac_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS      = 20;        // Module clock period, 50 MHz.
    localparam int TICK_NS     = 1000000;   // Timer resolution, one millisecond.
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_BLOCK  = 8'h04;
    localparam logic [7:0] REG_CLEAR  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int LINE_STRIDE = 8;   // Each aux line owns one byte of the control word.
    localparam int FN_LSB      = 0;   // Three bits of line function.
    localparam int ZONE_BIT    = 3;   // 0 binds the line to upstream, 1 to downstream.
    localparam int INV_BIT     = 4;   // Inverts the electrical sense of the line.
    localparam int MOST_UP_BIT = 16;  // Upstream zone is the head of the lane.
    localparam int MOST_DN_BIT = 17;  // Downstream zone is the tail of the lane.

    localparam logic [31:0] CTRL_RST  = 32'h0003_0000;
    localparam logic [15:0] BLOCK_RST = 16'h1388;   // 5000 ms.
    localparam logic [15:0] CLEAR_RST = 16'h1770;   // 6000 ms.
    localparam logic [15:0] JAM_MS    = 16'h07D0;   // 2000 ms arrival window.

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int ST_OCC_UP = 0;
    localparam int ST_OCC_DN = 1;
    localparam int ST_LANE   = 2;
    localparam int ST_JAM    = 3;
    localparam int ST_MOT_UP = 4;
    localparam int ST_MOT_DN = 5;
    localparam int ST_ACT0   = 6;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        FN_EXT  = 3'h0,
        FN_ACC  = 3'h1,
        FN_WAKE = 3'h2,
        FN_LANE = 3'h3,
        FN_OCC  = 3'h4
    } zac_fn_e;

    typedef enum logic [1:0]
    {
        Q_CLEAR    = 2'h0,
        Q_BLOCKING = 2'h1,
        Q_BLOCKED  = 2'h3,
        Q_CLEARING = 2'h2
    } zac_qual_e;

endpackage : zac_pkg

// >>> zac_zone_aux_ctrl.sv
// Function
// - Tail zone releases unless told to accumulate or jammed.
// - Accumulate input stops tail zone on arrival.
// - Head zone never self-starts to take items.
// - Wake-up input runs head zone to receive.
// - Middle zone passes item when next clear.
// - Accumulate input holds middle zone's next item.
// - Lane full accumulates after full block time.
// - Lane full releases after full clear time.
// - Lane full mode disables arrival jam check.
// - Lane clear releases arriving items at once.
// - Occupancy output shows head zone holding item.
// - Tail occupancy output signals item ready.
// - Each line binds to a selectable zone.
// - Inverted input is active when pin off.
// - Inverted occupancy output is off when occupied.
// - External-control lines leave zone logic untouched.
`timescale 1ns/1ps
`default_nettype none

module zac_zone_aux_ctrl
#(
    parameter int          TICK_CYCLES = zac_pkg::TICK_CYCLES,
    parameter logic [15:0] JAM_MS      = zac_pkg::JAM_MS
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sens_up_i,
    input  wire logic        sens_dn_i,
    input  wire logic        up_arrive_i,
    input  wire logic        ds_clear_i,
    input  wire logic        ds_arrive_i,
    input  wire logic [1:0]  aux_pin_i,
    output logic      [1:0]  aux_pin_o,
    output logic      [1:0]  aux_pin_oe_o,
    output logic             motor_up_o,
    output logic             motor_dn_o,
    output logic             jam_o
);

    localparam int TW = $clog2(TICK_CYCLES + 1);

    logic [31:0]   ctrl_ff;
    logic [15:0]   block_ff;
    logic [15:0]   clear_ff;
    logic [TW-1:0] tick_cnt_ff;
    logic          tick_ff;
    logic [1:0]    sup_ff;
    logic [1:0]    sdn_ff;
    logic          occ_dn_d_ff;
    logic          wait_ff;
    logic [15:0]   jam_cnt_ff;
    logic [1:0]    act;
    logic [2:0]    fn      [2];
    logic [1:0]    zsel;
    logic [1:0]    inv;
    logic [1:0]    drive;
    logic [1:0]    occ_sel;
    logic          lane_full;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wr       = req && wb_we_i;
    wire        hit_ctrl = wb_adr_i == zac_pkg::REG_CTRL;
    wire        hit_blk  = wb_adr_i == zac_pkg::REG_BLOCK;
    wire        hit_clr  = wb_adr_i == zac_pkg::REG_CLEAR;
    wire        hit_st   = wb_adr_i == zac_pkg::REG_STATUS;
    wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] ctrl_new = (ctrl_ff & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] blk_new  = ({16'h0000, block_ff} & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] clr_new  = ({16'h0000, clear_ff} & ~wmask) | (wb_dat_i & wmask);
    wire        jam_clr  = wr && hit_st && wb_sel_i[0] && wb_dat_i[zac_pkg::ST_JAM];

    // ------------------------------------------------------------------
    // Zone configuration and sensing
    // ------------------------------------------------------------------
    wire most_up = ctrl_ff[zac_pkg::MOST_UP_BIT];
    wire most_dn = ctrl_ff[zac_pkg::MOST_DN_BIT];
    wire occ_up  = sup_ff[1];
    wire occ_dn  = sdn_ff[1];

    // Each line is tied to one zone; external-control lines reach no term.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_line
            assign fn[gi]      = ctrl_ff[gi*zac_pkg::LINE_STRIDE + zac_pkg::FN_LSB +: 3];
            assign zsel[gi]    = ctrl_ff[gi*zac_pkg::LINE_STRIDE + zac_pkg::ZONE_BIT];
            assign inv[gi]     = ctrl_ff[gi*zac_pkg::LINE_STRIDE + zac_pkg::INV_BIT];
            assign drive[gi]   = fn[gi] == zac_pkg::FN_OCC;
            assign occ_sel[gi] = zsel[gi] ? occ_dn : occ_up;

            zac_aux_line u_line
            (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .pin_i    (aux_pin_i[gi]),
                .inv_i    (inv[gi]),
                .drive_i  (drive[gi]),
                .occ_i    (occ_sel[gi]),
                .act_o    (act[gi]),
                .pin_o    (aux_pin_o[gi]),
                .pin_oe_o (aux_pin_oe_o[gi])
            );
        end
    endgenerate

    // Per-zone decoded commands from both lines.
    wire acc_up  = (act[0] && fn[0] == zac_pkg::FN_ACC && !zsel[0])
                || (act[1] && fn[1] == zac_pkg::FN_ACC && !zsel[1]);
    wire acc_dn  = (act[0] && fn[0] == zac_pkg::FN_ACC && zsel[0])
                || (act[1] && fn[1] == zac_pkg::FN_ACC && zsel[1]);
    wire wake_up = (act[0] && fn[0] == zac_pkg::FN_WAKE && !zsel[0])
                || (act[1] && fn[1] == zac_pkg::FN_WAKE && !zsel[1]);
    wire lane_l0 = fn[0] == zac_pkg::FN_LANE && zsel[0];
    wire lane_l1 = fn[1] == zac_pkg::FN_LANE && zsel[1];
    wire lane_md = most_dn && (lane_l0 || lane_l1);
    wire lane_lv = (lane_l0 && act[0]) || (lane_l1 && act[1]);

    // ------------------------------------------------------------------
    // Zone motor decisions
    // ------------------------------------------------------------------
    // The head zone only loads on a wake-up; others also load from upstream.
    wire up_feed = !occ_up && (wake_up || (!most_up && up_arrive_i));
    wire up_rel  = occ_up && !acc_up && !occ_dn;
    wire dn_hold = acc_dn || (lane_md && lane_full);
    wire dn_gate = most_dn ? (lane_md || !jam_o) : ds_clear_i;
    wire dn_rel  = occ_dn && !dn_hold && dn_gate;
    wire nxt_mu  = up_feed || up_rel;
    wire nxt_md  = dn_rel || up_rel;
    wire left_dn = occ_dn_d_ff && !occ_dn && motor_dn_o;

    // Lane full qualification on the tail zone.
    zac_lane_qual #(.W(16)) u_lane
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_ff),
        .level_i    (lane_lv),
        .block_ms_i (block_ff),
        .clear_ms_i (clear_ff),
        .full_o     (lane_full)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Bus slave: one wait state, acknowledge for one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff  <= zac_pkg::CTRL_RST;
            block_ff <= zac_pkg::BLOCK_RST;
            clear_ff <= zac_pkg::CLEAR_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            if (wr && hit_ctrl)
                ctrl_ff <= ctrl_new;
            if (wr && hit_blk)
                block_ff <= blk_new[15:0];
            if (wr && hit_clr)
                clear_ff <= clr_new[15:0];
            if (req && !wb_we_i)
                wb_dat_o <= hit_ctrl ? ctrl_ff
                          : hit_blk  ? {16'h0000, block_ff}
                          : hit_clr  ? {16'h0000, clear_ff}
                          : hit_st   ? {24'h00_0000, act, motor_dn_o, motor_up_o,
                                        jam_o, lane_full, occ_dn, occ_up}
                          : 32'h0000_0000;
        end
    end

    // Millisecond tick divider.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end
        else
        begin
            tick_ff     <= tick_cnt_ff == TW'(TICK_CYCLES - 1);
            tick_cnt_ff <= (tick_cnt_ff == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_ff + TW'(1);
        end
    end

    // Sensor synchronisers and motor drives.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sup_ff      <= 2'h0;
            sdn_ff      <= 2'h0;
            occ_dn_d_ff <= 1'b0;
            motor_up_o  <= 1'b0;
            motor_dn_o  <= 1'b0;
        end
        else
        begin
            sup_ff      <= {sup_ff[0], sens_up_i};
            sdn_ff      <= {sdn_ff[0], sens_dn_i};
            occ_dn_d_ff <= occ_dn;
            motor_up_o  <= nxt_mu;
            motor_dn_o  <= nxt_md;
        end
    end

    // Arrival watch after a tail release; lane full mode skips it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wait_ff    <= 1'b0;
            jam_cnt_ff <= 16'h0000;
            jam_o      <= 1'b0;
        end
        else
        begin
            if (lane_md || !most_dn || ds_arrive_i)
                wait_ff <= 1'b0;
            else if (left_dn)
                wait_ff <= 1'b1;
            else if (wait_ff && jam_cnt_ff >= JAM_MS)
                wait_ff <= 1'b0;
            jam_cnt_ff <= !wait_ff ? 16'h0000 : jam_cnt_ff + {15'h0000, tick_ff};
            if (wait_ff && !lane_md && jam_cnt_ff >= JAM_MS)
                jam_o <= 1'b1;
            else if (jam_clr)
                jam_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    tail_release_a: assert property ((most_dn && occ_dn && !acc_dn && !lane_full && !jam_o
                                      && !lane_lv) |=> motor_dn_o)
        else $error("Tail zone failed to release.");
    tail_hold_a: assert property ((acc_dn && occ_dn) |=> !motor_dn_o)
        else $error("Accumulating tail zone kept running.");
    head_idle_a: assert property ((most_up && !wake_up && !occ_up && !up_rel) |=> !motor_up_o)
        else $error("Head zone started on its own.");
    wake_run_a: assert property ((wake_up && !occ_up) |=> motor_up_o)
        else $error("Wake-up did not run the head zone.");
    mid_move_a: assert property ((!most_dn && occ_dn && ds_clear_i && !acc_dn) |=> motor_dn_o)
        else $error("Middle zone did not pass its item.");
    mid_hold_a: assert property ((acc_up && occ_up && !up_feed) |=> !motor_up_o)
        else $error("Accumulating middle zone passed its item.");
    lane_nojam_a: assert property ($rose(jam_o) |-> !$past(lane_md))
        else $error("Jam raised in lane full mode.");
    occ_out_a: assert property (drive[1] |=> aux_pin_oe_o[1])
        else $error("Occupancy line not driven.");
    occ_level_a: assert property ((drive[0] && $stable(occ_sel[0]) && $stable(inv[0]))
                                  |=> aux_pin_o[0] == ($past(occ_sel[0]) ^ $past(inv[0])))
        else $error("Occupancy output level wrong.");
    ext_quiet_a: assert property ((fn[0] == zac_pkg::FN_EXT && fn[1] == zac_pkg::FN_EXT)
                                  |-> !acc_up && !acc_dn && !wake_up && !lane_lv)
        else $error("External-control line reached zone logic.");

    // ------------------------------------------------------------------
    // Checks on the occupancy lines and the lane full tail
    // ------------------------------------------------------------------
    // Occupancy lines follow their bound zone one cycle later.
    occ_head_a: assert property ((drive[1] && !zsel[1])
                                 |=> aux_pin_o[1] == ($past(occ_up) ^ $past(inv[1])))
        else $error("Head occupancy line wrong.");
    occ_tail_a: assert property ((drive[0] && zsel[0])
                                 |=> aux_pin_o[0] == ($past(occ_dn) ^ $past(inv[0])))
        else $error("Tail occupancy line wrong.");

    // Without an accumulate command, the qualified lane full level decides between hold and release.
    lane_hold_a: assert property ((lane_md && lane_full && occ_dn && !acc_dn)
                                  |=> !motor_dn_o)
        else $error("Lane full tail zone kept running.");
    lane_go_a: assert property ((lane_md && !lane_full && occ_dn && !acc_dn)
                                |=> motor_dn_o)
        else $error("Clear lane tail zone held its item.");

endmodule : zac_zone_aux_ctrl

`default_nettype wire

// >>> zac_zone_aux_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Bench for the aux line and zone control block
// ------------------------------------------------------------
module zac_zone_aux_ctrl_tb_top;
    logic        clk_i, rst_i, cyc, stb, we, ack, jam, mot_up, mot_dn;
    logic        sens_dn, arr_dn, clr_dn, feed, take, item;
    logic [7:0]  adr, fed;
    logic [31:0] dat_w, dat_r, q;
    logic [1:0]  ext, pin, pin_o, pin_oe;
    int          n_errors = 0;
    int          tests_run = 0;

    // The wire carries the module's drive where enabled, else the far side.
    assign pin = (pin_oe & pin_o) | (~pin_oe & ext);

    zac_zone_aux_ctrl #(.TICK_CYCLES(10), .JAM_MS(16'h0005)) i_dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .sens_up_i(item), .sens_dn_i(sens_dn), .up_arrive_i(1'b0), .ds_clear_i(clr_dn),
        .ds_arrive_i(arr_dn), .aux_pin_i(pin), .aux_pin_o(pin_o), .aux_pin_oe_o(pin_oe),
        .motor_up_o(mot_up), .motor_dn_o(mot_dn), .jam_o(jam)
    );

    zac_feeder_model i_feed
    (
        .clk_i(clk_i), .feed_i(feed), .take_i(take), .busy_i(pin[1]), .item_o(item),
        .fed_o(fed)
    );

    // Makes the 50 MHz clock.
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk

    // One classic cycle, held until ack is sampled high, then released.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
        begin
            n++;
            if (n > 40)
            begin
                $display("Error ack expected 1 seen 0");
                n_errors++;
                complete_run();
            end
            @(posedge clk_i);
        end
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt

    task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rd

    // Writes the control word and lets the pins and motors settle.
    task automatic cfg(input logic [31:0] d);
        wb(1'b1, 8'h00, d);
        wt(8);
    endtask : cfg

    // Main sequence of tests.
    initial
    begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, dat_w} = '0;
        {sens_dn, clr_dn, feed, take, ext} = '0;
        arr_dn = 1'b1;
        wt(16);
        rst_i <= 1'b0;
        wt(1);
        rd(8'h00, "ctrl", 32'h0003_0000);
        rd(8'h04, "block", 32'h0000_1388);
        rd(8'h08, "clear", 32'h0000_1770);
        chk("oe", 32'h0, {30'h0, pin_oe});
        wb(1'b1, 8'h04, 32'h0000_0003);
        wb(1'b1, 8'h08, 32'h0000_0004);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        rd(8'h10, "unmapped", 32'h0);
        rd(8'h04, "block", 32'h0000_0003);
        $display("test registers done");
        sens_dn <= 1'b1;
        ext     <= 2'b11;
        wt(8);
        chk("motor_dn", 32'h1, mot_dn);
        cfg(32'h0003_0900);
        chk("motor_dn", 32'h0, mot_dn);
        cfg(32'h0003_1900);
        chk("motor_dn", 32'h1, mot_dn);
        ext <= 2'b01;
        wt(8);
        chk("motor_dn", 32'h0, mot_dn);
        $display("test tail zone done");
        ext <= 2'b00;
        cfg(32'h0003_0002);
        chk("motor_up", 32'h0, mot_up);
        ext <= 2'b01;
        wt(8);
        chk("motor_up", 32'h1, mot_up);
        cfg(32'h0003_0402);
        feed <= 1'b1;
        wt(12);
        chk("occ_pin", 32'h1, pin[1]);
        chk("fed", 32'h1, fed);
        take <= 1'b1;
        wt(1);
        take <= 1'b0;
        wt(15);
        chk("fed", 32'h2, fed);
        feed <= 1'b0;
        cfg(32'h0003_1402);
        chk("occ_pin", 32'h0, pin[1]);
        take <= 1'b1;
        wt(1);
        take <= 1'b0;
        wt(8);
        chk("occ_pin", 32'h1, pin[1]);
        ext <= 2'b00;
        cfg(32'h0003_000C);
        chk("occ_pin", 32'h1, pin[0]);
        $display("test handshake done");
        clr_dn <= 1'b1;
        cfg(32'h0001_0000);
        chk("motor_dn", 32'h1, mot_dn);
        clr_dn <= 1'b0;
        wt(8);
        chk("motor_dn", 32'h0, mot_dn);
        sens_dn <= 1'b0;
        clr_dn  <= 1'b1;
        ext     <= 2'b10;
        cfg(32'h0001_0900);
        sens_dn <= 1'b1;
        wt(8);
        chk("motor_dn", 32'h0, mot_dn);
        ext     <= 2'b01;
        sens_dn <= 1'b0;
        feed    <= 1'b1;
        cfg(32'h0001_0001);
        chk("motor_up", 32'h0, mot_up);
        feed    <= 1'b0;
        take    <= 1'b1;
        wt(1);
        take    <= 1'b0;
        sens_dn <= 1'b1;
        $display("test middle zone done");
        ext <= 2'b00;
        cfg(32'h0003_0B00);
        ext <= 2'b10;
        wt(18);
        ext <= 2'b00;
        wt(3);
        ext <= 2'b10;
        wt(15);
        chk("motor_dn", 32'h1, mot_dn);
        wt(30);
        chk("motor_dn", 32'h0, mot_dn);
        ext <= 2'b00;
        wt(25);
        chk("motor_dn", 32'h0, mot_dn);
        wt(30);
        chk("motor_dn", 32'h1, mot_dn);
        sens_dn <= 1'b0;
        wt(4);
        sens_dn <= 1'b1;
        wt(4);
        chk("motor_dn", 32'h1, mot_dn);
        arr_dn  <= 1'b0;
        sens_dn <= 1'b0;
        wt(100);
        chk("jam", 32'h0, jam);
        $display("test lane full done");
        sens_dn <= 1'b1;
        cfg(32'h0003_0000);
        sens_dn <= 1'b0;
        wt(80);
        chk("jam", 32'h1, jam);
        rd(8'h0C, "status", 32'h0000_0008);
        wb(1'b1, 8'h0C, 32'h0000_0008);
        chk("jam", 32'h0, jam);
        $display("test jam done");
        complete_run();
    end
endmodule : zac_zone_aux_ctrl_tb_top

`default_nettype wire
